// file: hw/psu_supervisor_pkg.sv
package psu_supervisor_pkg;

  // Timebase
  localparam int unsigned CLK_FREQ_HZ    = 100_000_000;
  localparam int unsigned MS_PER_S       = 1000;
  localparam int unsigned MS_TICK_CYCLES = CLK_FREQ_HZ / MS_PER_S;

  typedef logic [15:0] ms_t;

  // Delays in milliseconds, counted on the millisecond tick
  localparam ms_t ON_DELAY_MS    = 16'h0005;
  localparam ms_t PWOK_ON_MS     = 16'h00C8;
  localparam ms_t PWOK_OFF_MS    = 16'h0005;
  localparam ms_t PWOK_LOW_MS    = 16'h0064;
  localparam ms_t PSON_CLEAR_MS  = 16'h03E8;
  localparam ms_t AC_CLEAR_MS    = 16'h3A98;

  // Diagnostic store defaults
  localparam int unsigned DIAG_DEPTH = 8;
  localparam int unsigned DIAG_WIDTH = 16;

  // Positions in the synchronised input vector
  localparam int IN_ON_N      = 0;
  localparam int IN_OC        = 1;
  localparam int IN_OV        = 2;
  localparam int IN_OT_HOT    = 3;
  localparam int IN_OT_COOL   = 4;
  localparam int IN_SB_OC     = 5;
  localparam int IN_SB_OV     = 6;
  localparam int IN_MAIN_REG  = 7;
  localparam int IN_SB_REG    = 8;
  localparam int IN_CUR_LIM   = 9;
  localparam int IN_AC        = 10;
  localparam int IN_TEMP_WARN = 11;
  localparam int IN_FAN_FAIL  = 12;
  localparam int IN_GEN_FAIL  = 13;
  localparam int SYNC_W       = 14;

  // On request idles inactive (high), everything else low
  localparam logic [SYNC_W-1:0] SYNC_RESET = 14'h0001;

  typedef enum logic [1:0] {
    rail_off,
    rail_delay,
    rail_on,
    rail_drain
  } rail_state_e;

endpackage

// file: hw/diag_mem_if.sv
interface diag_mem_if #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
);
  logic                     wr_en;
  logic [$clog2(DEPTH)-1:0] wr_addr;
  logic [WIDTH-1:0]         wr_data;
  logic                     rd_en;
  logic [$clog2(DEPTH)-1:0] rd_addr;
  logic [WIDTH-1:0]         rd_data;

  modport ctrl (
    output wr_en,
    output wr_addr,
    output wr_data,
    output rd_en,
    output rd_addr,
    input  rd_data
  );

  modport store (
    input  wr_en,
    input  wr_addr,
    input  wr_data,
    input  rd_en,
    input  rd_addr,
    output rd_data
  );
endinterface

// file: hw/input_sync3.sv
module input_sync3 #(
  parameter int unsigned      WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_q;

  // A change is taken only once the second and third stages agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_q[i] = (stage2[i] == stage3[i]) ? stage3[i] : q[i];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= RESET_VALUE;
      stage2 <= RESET_VALUE;
      stage3 <= RESET_VALUE;
      q      <= RESET_VALUE;
    end else begin
      stage1 <= d;
      stage2 <= stage1;
      stage3 <= stage2;
      q      <= next_q;
    end
  end
endmodule

// file: hw/diag_store.sv
module diag_store #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic core_clk,
  input  wire logic arst_n,
  diag_mem_if.store port
);
  // Storage is not reset so a snapshot survives a controller reset
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_rd_data;

  always_comb begin
    next_rd_data = port.rd_en ? mem[port.rd_addr] : port.rd_data;
  end

  always_ff @(posedge core_clk) begin
    if (port.wr_en) begin
      mem[port.wr_addr] <= port.wr_data;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      port.rd_data <= '0;
    end else begin
      port.rd_data <= next_rd_data;
    end
  end
endmodule

// file: hw/psu_protection_supervisor.sv
// Notes on behaviour
// - Protection trips switch off only the main rail, never the standby rail.
// - Latch clears after 15 s input power loss, or when request goes active after 1 s inactive.
// - Overcurrent trip turns the main rail off and latches it off.
// - Overcurrent latch released by request toggle or power loss; restart allowed.
// - Overvoltage trip latches main rail off, cleared like overcurrent.
// - Standby rail faults recover automatically once they clear, no latch.
// - Overtemperature shuts main rail off without latching; standby stays on.
// - Main rail returns by itself when temperature is back in limits.
// - Overtemperature recovery uses a separate cooler threshold as hysteresis.
// - Request low enables main rail; high or open turns it off.
// - Main rail reaches regulation 5 to 400 ms after request goes active.
// - Output-good drops within 50 ms of request going inactive.
// - Output-good high only while every output is in regulation.
// - Output-good low on undervoltage or prolonged input power loss.
// - Output-good delay timer cleared to zero while output-good is low and an output is in current limit.
// - Output-good rises 100 to 1000 ms after outputs reach regulation.
// - Output-good drops 1 to 200 ms before outputs leave regulation, except on a trip, when it falls in the same cycle as main_en.
// - Alert asserted on critical and warning events.
// - Alert is active low: low means alert.
// - Alert asserts together with the amber indicator.
// - Critical shutdown copies latest telemetry into the diagnostic store.
// - Diagnostic store readable with only standby power present.
// - Output-good stays low at least 100 ms over an off/on cycle.
module psu_protection_supervisor #(
  parameter int unsigned TICK_CYCLES = psu_supervisor_pkg::MS_TICK_CYCLES,
  parameter int unsigned DIAG_DEPTH  = psu_supervisor_pkg::DIAG_DEPTH,
  parameter int unsigned DIAG_WIDTH  = psu_supervisor_pkg::DIAG_WIDTH
) (
  input  wire logic                          core_clk,
  input  wire logic                          arst_n,
  input  wire logic                          on_req_n,
  input  wire logic                          overcurrent_trip,
  input  wire logic                          overvoltage_trip,
  input  wire logic                          overtemp_trip,
  input  wire logic                          temp_recovered,
  input  wire logic                          standby_overcurrent,
  input  wire logic                          standby_overvoltage,
  input  wire logic                          main_in_reg,
  input  wire logic                          standby_in_reg,
  input  wire logic                          current_limit,
  input  wire logic                          ac_present,
  input  wire logic                          temp_warning,
  input  wire logic                          fan_fail,
  input  wire logic                          general_fail,
  input  wire logic [DIAG_WIDTH-1:0]         telemetry_word,
  input  wire logic                          diag_rd_en,
  input  wire logic [$clog2(DIAG_DEPTH)-1:0] diag_rd_addr,
  output logic                               main_en,
  output logic                               standby_rail_en,
  output logic                               pwok,
  output logic                               smbalert_n_out,
  output logic                               smbalert_oe,
  output logic                               led_amber_solid,
  output logic                               led_amber_blink,
  output logic [$clog2(DIAG_DEPTH)-1:0]      telemetry_index,
  output logic                               diag_busy,
  output logic [DIAG_WIDTH-1:0]              diag_rd_data
);
  import psu_supervisor_pkg::*;

  localparam int unsigned TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam int unsigned AW = $clog2(DIAG_DEPTH);

  // Input synchronisation
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] syn;

  assign raw = {general_fail, fan_fail, temp_warning, ac_present, current_limit,
                standby_in_reg, main_in_reg, standby_overvoltage, standby_overcurrent,
                temp_recovered, overtemp_trip, overvoltage_trip, overcurrent_trip,
                on_req_n};

  input_sync3 #(
    .WIDTH       (SYNC_W),
    .RESET_VALUE (SYNC_RESET)
  ) u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .d        (raw),
    .q        (syn)
  );

  logic on_active;
  logic ac_ok;
  logic trip_now;

  assign on_active = !syn[IN_ON_N];
  assign ac_ok     = syn[IN_AC];
  assign trip_now  = syn[IN_OC] || syn[IN_OV];

  // Millisecond tick
  logic [TW-1:0] tick_cnt;
  logic [TW-1:0] next_tick_cnt;
  logic          tick;
  logic          next_tick;

  always_comb begin
    next_tick     = 1'b0;
    next_tick_cnt = tick_cnt + TW'(1);
    if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
      next_tick_cnt = '0;
      next_tick     = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      tick     <= next_tick;
    end
  end

  // Protection latches and release timers
  logic prot_latch;
  logic next_prot_latch;
  logic ot_off;
  logic next_ot_off;
  ms_t  off_ms;
  ms_t  next_off_ms;
  ms_t  ac_ms;
  ms_t  next_ac_ms;
  logic release_armed;
  logic ac_release;

  assign release_armed = (off_ms >= PSON_CLEAR_MS);
  assign ac_release    = (ac_ms >= AC_CLEAR_MS);

  always_comb begin
    next_off_ms = off_ms;
    if (on_active) begin
      next_off_ms = '0;
    end else if (tick && !release_armed) begin
      next_off_ms = off_ms + 16'h0001;
    end
    next_ac_ms = ac_ms;
    if (ac_ok) begin
      next_ac_ms = '0;
    end else if (tick && !ac_release) begin
      next_ac_ms = ac_ms + 16'h0001;
    end
    next_prot_latch = prot_latch;
    if (trip_now) begin
      next_prot_latch = 1'b1;
    end else if ((release_armed && on_active) || ac_release) begin
      next_prot_latch = 1'b0;
    end
    next_ot_off = ot_off;
    if (syn[IN_OT_HOT]) begin
      next_ot_off = 1'b1;
    end else if (syn[IN_OT_COOL]) begin
      next_ot_off = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prot_latch <= 1'b0;
      ot_off     <= 1'b0;
      off_ms     <= '0;
      ac_ms      <= '0;
    end else begin
      prot_latch <= next_prot_latch;
      ot_off     <= next_ot_off;
      off_ms     <= next_off_ms;
      ac_ms      <= next_ac_ms;
    end
  end

  // Main rail sequencing
  logic        shutdown;
  logic        run_ok;
  rail_state_e state;
  rail_state_e next_state;
  ms_t         seq_ms;
  ms_t         next_seq_ms;
  logic        next_main_en;
  logic        next_standby_rail_en;

  assign shutdown = prot_latch || ot_off || trip_now || syn[IN_OT_HOT];
  assign run_ok   = on_active && ac_ok && !shutdown;

  always_comb begin
    next_state  = state;
    next_seq_ms = seq_ms;
    case (state)
      rail_off: begin
        if (run_ok) begin
          next_state  = rail_delay;
          next_seq_ms = '0;
        end
      end
      rail_delay: begin
        if (!run_ok) begin
          next_state = rail_off;
        end else if (tick) begin
          next_seq_ms = seq_ms + 16'h0001;
          // Count one tick past the delay: the first tick may land just after entry
          if (next_seq_ms > ON_DELAY_MS) begin
            next_state = rail_on;
          end
        end
      end
      rail_on: begin
        if (shutdown) begin
          next_state = rail_off;
        end else if (!on_active || !ac_ok) begin
          next_state  = rail_drain;
          next_seq_ms = '0;
        end
      end
      rail_drain: begin
        if (shutdown) begin
          next_state = rail_off;
        end else if (tick) begin
          next_seq_ms = seq_ms + 16'h0001;
          if (next_seq_ms >= PWOK_OFF_MS) begin
            next_state = rail_off;
          end
        end
      end
      default: begin
        next_state = rail_off;
      end
    endcase
    next_main_en = (next_state == rail_on) || (next_state == rail_drain);
    // Standby rail follows its own faults only
    next_standby_rail_en = !(syn[IN_SB_OC] || syn[IN_SB_OV]);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state           <= rail_off;
      seq_ms          <= '0;
      main_en         <= 1'b0;
      standby_rail_en <= 1'b0;
    end else begin
      state           <= next_state;
      seq_ms          <= next_seq_ms;
      main_en         <= next_main_en;
      standby_rail_en <= next_standby_rail_en;
    end
  end

  // Output-good timing
  logic pwok_good;
  logic next_pwok;
  ms_t  pwok_ms;
  ms_t  next_pwok_ms;
  ms_t  low_ms;
  ms_t  next_low_ms;

  assign pwok_good = (state == rail_on) && syn[IN_MAIN_REG] && syn[IN_SB_REG]
                     && ac_ok && on_active && !shutdown;

  always_comb begin
    next_pwok    = pwok;
    next_pwok_ms = pwok_ms;
    if (!pwok_good) begin
      next_pwok    = 1'b0;
      next_pwok_ms = '0;
    end else if (!pwok && syn[IN_CUR_LIM]) begin
      next_pwok_ms = '0;
    end else if (!pwok && tick) begin
      next_pwok_ms = pwok_ms + 16'h0001;
      if (next_pwok_ms >= PWOK_ON_MS && low_ms >= PWOK_LOW_MS) begin
        next_pwok = 1'b1;
      end
    end
    next_low_ms = low_ms;
    if (pwok) begin
      next_low_ms = '0;
    end else if (tick && low_ms < PWOK_LOW_MS) begin
      next_low_ms = low_ms + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwok    <= 1'b0;
      pwok_ms <= '0;
      low_ms  <= '0;
    end else begin
      pwok    <= next_pwok;
      pwok_ms <= next_pwok_ms;
      low_ms  <= next_low_ms;
    end
  end

  // Alert and amber indicator
  logic uv_flag;
  logic next_uv_flag;
  logic critical;
  logic warning;
  logic next_amber_solid;
  logic next_amber_blink;
  logic next_alert_oe;

  assign critical = prot_latch || ot_off || syn[IN_FAN_FAIL] || syn[IN_GEN_FAIL];
  assign warning  = syn[IN_TEMP_WARN] || uv_flag;

  always_comb begin
    next_uv_flag = uv_flag;
    if (state != rail_on) begin
      next_uv_flag = 1'b0;
    end else if (pwok && !syn[IN_MAIN_REG]) begin
      next_uv_flag = 1'b1;
    end
    next_amber_solid = critical;
    next_amber_blink = warning && !critical;
    next_alert_oe    = critical || warning;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      uv_flag         <= 1'b0;
      led_amber_solid <= 1'b0;
      led_amber_blink <= 1'b0;
      smbalert_oe     <= 1'b0;
      smbalert_n_out  <= 1'b0;
    end else begin
      uv_flag         <= next_uv_flag;
      led_amber_solid <= next_amber_solid;
      led_amber_blink <= next_amber_blink;
      smbalert_oe     <= next_alert_oe;
      smbalert_n_out  <= 1'b0;
    end
  end

  // Diagnostic snapshot on a new critical event
  diag_mem_if #(.WIDTH(DIAG_WIDTH), .DEPTH(DIAG_DEPTH)) diag_bus ();

  logic          next_diag_busy;
  logic [AW-1:0] next_index;

  always_comb begin
    next_diag_busy = diag_busy;
    next_index     = telemetry_index;
    if (!diag_busy && critical && !led_amber_solid) begin
      next_diag_busy = 1'b1;
      next_index     = '0;
    end else if (diag_busy) begin
      next_index = telemetry_index + AW'(1);
      if (telemetry_index == AW'(DIAG_DEPTH - 1)) begin
        next_diag_busy = 1'b0;
        next_index     = '0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      diag_busy       <= 1'b0;
      telemetry_index <= '0;
    end else begin
      diag_busy       <= next_diag_busy;
      telemetry_index <= next_index;
    end
  end

  assign diag_bus.wr_en   = diag_busy;
  assign diag_bus.wr_addr = telemetry_index;
  assign diag_bus.wr_data = telemetry_word;
  assign diag_bus.rd_en   = diag_rd_en;
  assign diag_bus.rd_addr = diag_rd_addr;
  assign diag_rd_data     = diag_bus.rd_data;

  diag_store #(
    .WIDTH (DIAG_WIDTH),
    .DEPTH (DIAG_DEPTH)
  ) u_store (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .port     (diag_bus.store)
  );

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_req_start;
    $fell(syn[IN_ON_N]) && state == rail_off && !shutdown && ac_ok;
  endsequence

  property p_oc_off;
    syn[IN_OC] |=> !main_en && prot_latch;
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("main on after trip");

  property p_ot_off;
    syn[IN_OT_HOT] |=> !main_en ##0 ot_off;
  endproperty
  a_ot_off: assert property (p_ot_off) else $error("main on at overtemp");

  property p_standby_kept;
    (trip_now && !syn[IN_SB_OC] && !syn[IN_SB_OV]) |=> standby_rail_en;
  endproperty
  a_standby_kept: assert property (p_standby_kept) else $error("standby cut");

  property p_no_early_main;
    s_req_start |=> !main_en [*3];
  endproperty
  a_no_early_main: assert property (p_no_early_main) else $error("main too early");

  property p_pwok_in_reg;
    pwok |-> $past(syn[IN_MAIN_REG]) && $past(syn[IN_SB_REG]) && main_en;
  endproperty
  a_pwok_in_reg: assert property (p_pwok_in_reg) else $error("pwok out of reg");

  property p_pwok_drop;
    (pwok && syn[IN_ON_N]) |=> !pwok;
  endproperty
  a_pwok_drop: assert property (p_pwok_drop) else $error("pwok held off");

  property p_drain_hold;
    ($fell(pwok) && state == rail_drain && !shutdown) |-> main_en ##1 main_en;
  endproperty
  a_drain_hold: assert property (p_drain_hold) else $error("rail off early");

  property p_pwok_rise;
    $rose(pwok) |-> $past(low_ms) >= PWOK_LOW_MS && !$past(syn[IN_CUR_LIM]);
  endproperty
  a_pwok_rise: assert property (p_pwok_rise) else $error("pwok rose early");

  property p_alert;
    (critical || warning) |=> smbalert_oe && !smbalert_n_out;
  endproperty
  a_alert: assert property (p_alert) else $error("alert missing");

  property p_alert_amber;
    smbalert_oe == (led_amber_solid || led_amber_blink);
  endproperty
  a_alert_amber: assert property (p_alert_amber) else $error("alert vs amber");

  property p_release;
    $fell(prot_latch) |-> $past(release_armed && on_active) || $past(ac_release);
  endproperty
  a_release: assert property (p_release) else $error("bad release");
endmodule

// file: verification/board_ctrl_model.sv
module board_ctrl_model (
  input  wire logic        core_clk,
  input  wire logic        req_on,
  input  wire logic [2:0]  telemetry_index,
  output logic             on_req_n,
  output logic [15:0]      telemetry_word
);
  timeunit 1ns;
  timeprecision 1ps;

  initial on_req_n = 1'b1;

  // Board pulls the request low to run, releases it high otherwise
  always @(posedge core_clk) begin
    on_req_n <= !req_on;
  end

  // Telemetry word tracks the index so each saved slot is distinct
  assign telemetry_word = 16'h5A00 | {13'h0000, telemetry_index};
endmodule

// file: verification/tb_psu_protection_supervisor.sv
module tb_psu_protection_supervisor;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int T = 4;

  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        req_on = 1'b0;
  logic        on_req_n;
  logic        oc = 1'b0;
  logic        ov = 1'b0;
  logic        ot = 1'b0;
  logic        t_rec = 1'b0;
  logic        sb_oc = 1'b0;
  logic        sb_ov = 1'b0;
  logic        main_in_reg = 1'b0;
  logic        current_limit = 1'b0;
  logic        ac = 1'b1;
  logic        sb_reg = 1'b1;
  logic [2:0]  warn = 3'h0;
  logic [15:0] telemetry_word;
  logic        diag_rd_en = 1'b0;
  logic [2:0]  diag_rd_addr = 3'h0;
  logic        main_en;
  logic        standby_rail_en;
  logic        pwok;
  logic        smbalert_n_out;
  logic        smbalert_oe;
  logic        amber_solid;
  logic        amber_blink;
  logic [2:0]  telemetry_index;
  logic        diag_busy;
  logic [15:0] diag_rd_data;
  int          bad_count = 0;
  int          cmp_count = 0;

  psu_protection_supervisor #(.TICK_CYCLES(T)) dut (
    .core_clk(core_clk), .arst_n(arst_n), .on_req_n(on_req_n),
    .overcurrent_trip(oc), .overvoltage_trip(ov), .overtemp_trip(ot),
    .temp_recovered(t_rec), .standby_overcurrent(sb_oc), .standby_overvoltage(sb_ov),
    .main_in_reg(main_in_reg), .standby_in_reg(sb_reg), .current_limit(current_limit),
    .ac_present(ac), .temp_warning(warn[0]), .fan_fail(warn[1]),
    .general_fail(warn[2]), .telemetry_word(telemetry_word),
    .diag_rd_en(diag_rd_en), .diag_rd_addr(diag_rd_addr), .main_en(main_en),
    .standby_rail_en(standby_rail_en), .pwok(pwok), .smbalert_n_out(smbalert_n_out),
    .smbalert_oe(smbalert_oe), .led_amber_solid(amber_solid),
    .led_amber_blink(amber_blink), .telemetry_index(telemetry_index),
    .diag_busy(diag_busy), .diag_rd_data(diag_rd_data)
  );

  board_ctrl_model partner (
    .core_clk(core_clk), .req_on(req_on), .telemetry_index(telemetry_index),
    .on_req_n(on_req_n), .telemetry_word(telemetry_word)
  );

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return main_en;
      1: return pwok;
      2: return standby_rail_en;
      3: return smbalert_oe;
      default: return diag_busy;
    endcase
  endfunction

  // Bounded wait, returns settled one step after the edge
  task automatic wait_for(input int s, input logic v, input int lim, output int n);
    n = 0;
    while (sig(s) !== v && n < lim) begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask

  task automatic do_reset;
    @(posedge core_clk);
    arst_n <= 1'b0;
    {req_on, oc, ov, ot, t_rec, sb_oc, sb_ov, main_in_reg, current_limit} <= '0;
    warn <= 3'h0;
    {ac, sb_reg} <= 2'h3;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic power_up;
    int n;
    @(posedge core_clk);
    req_on <= 1'b1;
    wait_for(0, 1'b1, 500*T, n);
    @(posedge core_clk);
    main_in_reg <= 1'b1;
    wait_for(1, 1'b1, 1100*T, n);
    check("pwok after power up", pwok, 1'b1);
  endtask

  task automatic s_reset_state;
    do_reset;
    check("standby on", standby_rail_en, 1'b1);
    check("main idle", main_en, 1'b0);
    check("alert idle", smbalert_oe, 1'b0);
    check("alert data", smbalert_n_out, 1'b0);
  endtask

  task automatic s_turn_on;
    int n;
    do_reset;
    @(posedge core_clk);
    req_on <= 1'b1;
    wait_for(0, 1'b1, 500*T, n);
    check("main rise window", n >= 5*T && n <= 400*T, 1'b1);
    @(posedge core_clk);
    current_limit <= 1'b1;
    main_in_reg <= 1'b1;
    wait_for(1, 1'b1, 300*T, n);
    check("pwok held in limit", pwok, 1'b0);
    @(posedge core_clk);
    current_limit <= 1'b0;
    wait_for(1, 1'b1, 1100*T, n);
    check("pwok delay window", n >= 100*T && n <= 1000*T, 1'b1);
    @(posedge core_clk);
    main_in_reg <= 1'b0;
    wait_for(1, 1'b0, 8, n);
    check("pwok on undervoltage", pwok, 1'b0);
    wait_for(3, 1'b1, 8, n);
    check("alert on undervoltage", smbalert_oe, 1'b1);
  endtask

  task automatic s_turn_off;
    int n;
    do_reset;
    power_up;
    @(posedge core_clk);
    req_on <= 1'b0;
    wait_for(1, 1'b0, 50*T, n);
    check("pwok off", pwok, 1'b0);
    wait_for(0, 1'b0, 250*T, n);
    check("pwok lead window", n >= T && n <= 200*T, 1'b1);
  endtask

  task automatic s_latch(input int k);
    int n;
    do_reset;
    power_up;
    @(posedge core_clk);
    if (k == 0) oc <= 1'b1;
    else ov <= 1'b1;
    wait_for(0, 1'b0, 8, n);
    check("main tripped", main_en, 1'b0);
    check("standby kept", standby_rail_en, 1'b1);
    wait_for(3, 1'b1, 4, n);
    check("critical amber", {smbalert_oe, amber_solid}, 2'h3);
    check("snapshot start", {diag_busy, telemetry_index}, 4'h8);
    @(posedge core_clk);
    {oc, ov, main_in_reg} <= '0;
    wait_for(4, 1'b0, 50, n);
    for (int a = 0; a < 8; a++) begin
      @(posedge core_clk);
      diag_rd_en <= 1'b1;
      diag_rd_addr <= 3'(a);
      @(posedge core_clk);
      diag_rd_en <= 1'b0;
      #1;
      check("saved word", diag_rd_data, 16'h5A00 | a);
    end
    repeat (20*T) @(posedge core_clk);
    req_on <= 1'b0;
    repeat (200*T) @(posedge core_clk);
    req_on <= 1'b1;
    repeat (50*T) @(posedge core_clk);
    #1;
    check("latch held", main_en, 1'b0);
    @(posedge core_clk);
    req_on <= 1'b0;
    repeat (1010*T) @(posedge core_clk);
    req_on <= 1'b1;
    wait_for(0, 1'b1, 500*T, n);
    check("latch released", main_en, 1'b1);
  endtask

  task automatic s_overtemp;
    int n;
    do_reset;
    power_up;
    @(posedge core_clk);
    ot <= 1'b1;
    wait_for(0, 1'b0, 8, n);
    check("hot main", main_en, 1'b0);
    check("hot standby", standby_rail_en, 1'b1);
    @(posedge core_clk);
    ot <= 1'b0;
    repeat (50*T) @(posedge core_clk);
    #1;
    check("inside hysteresis", main_en, 1'b0);
    @(posedge core_clk);
    t_rec <= 1'b1;
    wait_for(0, 1'b1, 500*T, n);
    check("auto restart", main_en, 1'b1);
  endtask

  task automatic s_standby(input int k);
    int n;
    do_reset;
    @(posedge core_clk);
    if (k == 0) sb_oc <= 1'b1;
    else sb_ov <= 1'b1;
    wait_for(2, 1'b0, 8, n);
    check("standby fault off", standby_rail_en, 1'b0);
    @(posedge core_clk);
    {sb_oc, sb_ov} <= '0;
    wait_for(2, 1'b1, 8, n);
    check("standby recovers", standby_rail_en, 1'b1);
  endtask

  task automatic s_warn(input int k);
    int n;
    do_reset;
    power_up;
    @(posedge core_clk);
    warn <= 3'(1 << k);
    wait_for(3, 1'b1, 8, n);
    check("event alert", smbalert_oe, 1'b1);
    check("amber with alert", amber_solid | amber_blink, 1'b1);
    check("amber kind", {amber_solid, amber_blink}, (k == 0) ? 2'h1 : 2'h2);
  endtask

  task automatic s_ac_loss(input int k);
    int n;
    do_reset;
    power_up;
    @(posedge core_clk);
    if (k == 0) sb_reg <= 1'b0;
    else ac <= 1'b0;
    wait_for(1, 1'b0, 8, n);
    check("pwok on rail or input loss", pwok, 1'b0);
    if (k != 0) begin
      wait_for(0, 1'b0, 250*T, n);
      check("main after input loss", n >= T && n <= 200*T, 1'b1);
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge core_clk);
    bad_count++;
    give_verdict;
  end

  initial begin
    s_reset_state;
    s_turn_on;
    s_turn_off;
    for (int k = 0; k < 2; k++) s_latch(k);
    s_overtemp;
    for (int k = 0; k < 2; k++) s_standby(k);
    for (int k = 0; k < 3; k++) s_warn(k);
    for (int k = 0; k < 2; k++) s_ac_loss(k);
    give_verdict;
  end
endmodule
